// ---- common/timer_pair_map.vh ----
// timer pair constants: control bit positions, reset values, tick rate
// assumes a single clock feeding the divider and both timers
`ifndef TIMER_PAIR_MAP_VH
`define TIMER_PAIR_MAP_VH

// timer control low bit positions
`define CTL_EVEN_ENABLE 0
`define CTL_ODD_ENABLE 1
`define CTL_JOINED 2
`define CTL_EVEN_ONESHOT 3
`define CTL_ODD_ONESHOT 4
// implemented bits of timer control low, others read zero
`define CTL_USED_MASK 8'h1F

// reset values
`define CTL_RESET 8'h00
`define COUNT_RESET 8'h00
`define RELOAD_RESET 8'h00

// one timer update per this many crystal clocks
`define TICK_DIVIDE 8
`define TICK_COUNT_WIDTH 3

// count value one tick before terminal count
`define COUNT8_LAST 8'h01
`define COUNT16_LAST 16'h0001

`endif

// ---- design/tick_divider.v ----
// update tick generator: one pulse every DIVIDE reference clocks
// assumes rst asynchronous active high, ref_clk free running
`default_nettype none

module tick_divider #(
  parameter DIVIDE = 8,
  parameter WIDTH = 3
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // tick out
  output reg tick
);

  reg [WIDTH-1:0] phase;

  // free-running phase counter, tick on the last phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else begin
      if (phase == DIVIDE[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        phase <= {WIDTH{1'b0}};
        tick <= 1'b1;
      end else begin
        phase <= phase + {{(WIDTH-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
  end

endmodule // tick_divider

`default_nettype wire

// ---- design/cascaded_down_timer_pair.v ----
// pair of 8-bit down timers, joinable into one 16-bit timer
// assumes software access arrives as write strobes on plain ports,
// synchronous to ref_clk; register contents are always visible on outputs
//
// Functional notes
// - joined mode interrupts only at 16-bit zero
// - joined mode posts one request, even timer's
// - even holds low byte, odd high byte
// - reload count in same cycle as request
// - joined mode always auto-reloads, ignoring single-shot
// - joined timer free-runs while request pending
// - repeated zero before service needs no flag
// - enabling write starts from current count, no reload
// - internal tick only, every eighth crystal clock
// - reset leaves all timers disabled
// - hardware single-shot clear beats software write
// - reads anytime, no side effect
// - control low reads zero after reset
`include "timer_pair_map.vh"
`default_nettype none

module cascaded_down_timer_pair #(
  parameter TICK_DIVIDE = `TICK_DIVIDE,
  parameter TICK_WIDTH = `TICK_COUNT_WIDTH
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // software writes
  input wire controlWrite,
  input wire evenCountWrite,
  input wire oddCountWrite,
  input wire evenReloadWrite,
  input wire oddReloadWrite,
  input wire [7:0] writeData,
  // register contents for software reads
  output reg [7:0] timerControlLow,
  output reg [7:0] evenCountValue,
  output reg [7:0] oddCountValue,
  output reg [7:0] evenReloadValue,
  output reg [7:0] oddReloadValue,
  // interrupt requests, one-cycle pulses
  output reg evenIrq,
  output reg oddIrq
);

  wire tick;
  reg [7:0] next_control;
  reg [7:0] next_evenCount;
  reg [7:0] next_oddCount;
  reg next_evenIrq;
  reg next_oddIrq;
  reg [9:0] evenStep;
  reg [9:0] oddStep;
  reg [15:0] joinedCount;

  // one 8-bit timer step: {post, clearEnable, nextCount}
  function [9:0] step8;
    input [7:0] count;
    input [7:0] reload;
    input oneShot;
    begin
      if (count == `COUNT8_LAST) begin
        if (oneShot)
          step8 = {1'b1, 1'b1, 8'h00};
        else
          step8 = {1'b1, 1'b0, reload};
      end else begin
        step8 = {1'b0, 1'b0, count - 8'h01};
      end
    end
  endfunction

  // internal update tick, no external clock source
  tick_divider #(
    .DIVIDE(TICK_DIVIDE),
    .WIDTH(TICK_WIDTH)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  // next state of control, counts and requests
  always @* begin
    next_control = timerControlLow;
    next_evenCount = evenCountValue;
    next_oddCount = oddCountValue;
    next_evenIrq = 1'b0;
    next_oddIrq = 1'b0;
    evenStep = step8(evenCountValue, evenReloadValue,
      timerControlLow[`CTL_EVEN_ONESHOT]);
    oddStep = step8(oddCountValue, oddReloadValue,
      timerControlLow[`CTL_ODD_ONESHOT]);
    joinedCount = {oddCountValue, evenCountValue};
    // enabling only flips bits; counts are untouched
    if (controlWrite)
      next_control = writeData & `CTL_USED_MASK;
    if (tick && timerControlLow[`CTL_JOINED]) begin
      // joined: even enable runs the 16-bit counter
      if (timerControlLow[`CTL_EVEN_ENABLE]) begin
        if (joinedCount == `COUNT16_LAST) begin
          next_evenIrq = 1'b1;
          // reload regardless of single-shot bits
          next_evenCount = evenReloadValue;
          next_oddCount = oddReloadValue;
        end else begin
          // keeps running even with a request pending
          {next_oddCount, next_evenCount} = joinedCount - 16'h0001;
        end
      end
    end else if (tick) begin
      // split: two independent 8-bit timers
      if (timerControlLow[`CTL_EVEN_ENABLE]) begin
        next_evenIrq = evenStep[9];
        next_evenCount = evenStep[7:0];
        if (evenStep[8])
          next_control[`CTL_EVEN_ENABLE] = 1'b0;
      end
      if (timerControlLow[`CTL_ODD_ENABLE]) begin
        next_oddIrq = oddStep[9];
        next_oddCount = oddStep[7:0];
        if (oddStep[8])
          next_control[`CTL_ODD_ENABLE] = 1'b0;
      end
    end
    // software count writes override the tick update
    if (evenCountWrite)
      next_evenCount = writeData;
    if (oddCountWrite)
      next_oddCount = writeData;
  end

  // state registers; reads are plain wires, so no side effects
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timerControlLow <= `CTL_RESET;
      evenCountValue <= `COUNT_RESET;
      oddCountValue <= `COUNT_RESET;
      evenReloadValue <= `RELOAD_RESET;
      oddReloadValue <= `RELOAD_RESET;
      evenIrq <= 1'b0;
      oddIrq <= 1'b0;
    end else begin
      timerControlLow <= next_control;
      evenCountValue <= next_evenCount;
      oddCountValue <= next_oddCount;
      if (evenReloadWrite)
        evenReloadValue <= writeData;
      if (oddReloadWrite)
        oddReloadValue <= writeData;
      evenIrq <= next_evenIrq;
      oddIrq <= next_oddIrq; // joined mode never posts here
    end
  end

endmodule // cascaded_down_timer_pair

`default_nettype wire

// ---- sim/timer_pair_chk.sv ----
// checker: timing relations at the timer pair ports
// assumes bind onto cascaded_down_timer_pair with a tick every 8 clocks
`default_nettype none
module timer_pair_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched ports
  input wire logic evenCountWrite,
  input wire logic [7:0] timerControlLow,
  input wire logic [7:0] evenCountValue,
  input wire logic [7:0] oddCountValue,
  input wire logic [7:0] evenReloadValue,
  input wire logic [7:0] oddReloadValue,
  input wire logic evenIrq,
  input wire logic oddIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // count moved without a software write, so a tick did it
  sequence tickStep;
    $changed(evenCountValue) && !$past(evenCountWrite);
  endsequence
  AST_IRQ_RELOAD: assert property (evenIrq && timerControlLow[2] |->
    {oddCountValue, evenCountValue} == {oddReloadValue, evenReloadValue}) else $error("no reload");
  AST_JOINED_NO_ODD: assert property ($past(timerControlLow[2]) |-> !oddIrq)
    else $error("odd irq in joined mode");
  AST_IRQ_PULSE: assert property (evenIrq |=> !evenIrq) else $error("irq too long");
  AST_JOINED_ZERO: assert property (evenIrq && $past(timerControlLow[2]) |->
    $past({oddCountValue, evenCountValue}) == 16'h0001) else $error("irq before zero");
  AST_JOINED_KEEP: assert property (evenIrq && $past(timerControlLow[2]) |->
    timerControlLow[0]) else $error("joined timer stopped");
  AST_TICK_SPACING: assert property (tickStep |=>
    ($stable(evenCountValue) || $past(evenCountWrite))[*7]) else $error("tick too soon");
  AST_ENABLED_ONLY: assert property ($changed(evenCountValue) |-> $past(evenCountWrite) ||
    $past(timerControlLow[0]) || timerControlLow[0]) else $error("count while disabled");
  AST_DECREMENT: assert property (tickStep ##0 !evenIrq |->
    evenCountValue == $past(evenCountValue) - 8'h01) else $error("bad decrement");
endmodule // timer_pair_chk
bind cascaded_down_timer_pair timer_pair_chk watch (.ref_clk(ref_clk), .rst(rst),
  .evenCountWrite(evenCountWrite), .timerControlLow(timerControlLow),
  .evenCountValue(evenCountValue), .oddCountValue(oddCountValue),
  .evenReloadValue(evenReloadValue), .oddReloadValue(oddReloadValue),
  .evenIrq(evenIrq), .oddIrq(oddIrq));
`default_nettype wire

// ---- sim/testbench.sv ----
// testbench: strobes writes into the timer pair and checks the outputs
// assumes 25 MHz ref_clk and asynchronous active high rst
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0;
  logic rst = 1;
  logic [4:0] stb = '0;
  logic [7:0] wd = '0;
  logic [7:0] ctl, ec, oc, er, orl;
  logic ei, oi;
  int n_mismatch = 0;
  int n_compared = 0;
  cascaded_down_timer_pair dut (.ref_clk(ref_clk), .rst(rst), .controlWrite(stb[0]),
    .evenCountWrite(stb[1]), .oddCountWrite(stb[2]), .evenReloadWrite(stb[3]),
    .oddReloadWrite(stb[4]), .writeData(wd), .timerControlLow(ctl), .evenCountValue(ec),
    .oddCountValue(oc), .evenReloadValue(er), .oddReloadValue(orl), .evenIrq(ei), .oddIrq(oi));
  initial forever #20 ref_clk = ~ref_clk;
  // one strobe for one cycle; 0 ctl, 1 even cnt, 2 odd cnt, 3 even rld, 4 odd rld
  task automatic wr(input int s, input logic [7:0] d);
    @(posedge ref_clk);
    stb[s] <= 1'b1;
    wd <= d;
    @(posedge ref_clk);
    stb <= '0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // sample just after the edge so registered outputs have settled
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitIrq(input int lim, output int t);
    t = 0;
    while (ei !== 1'b1 && oi !== 1'b1 && t < lim) begin
      step(1);
      t++;
    end
  endtask
  task automatic resetCheck;
    step(1);
    chk("control", 16'h0000, ctl);
    wr(0, 8'hE0);
    step(20);
    chk("control", 16'h0000, ctl);
    chk("idle count", 16'h0000, {oc, ec});
  endtask
  // split continuous even timer reloads at terminal count
  task automatic splitReload;
    int t;
    wr(0, 8'h00);
    wr(3, 8'h05);
    wr(1, 8'h01);
    wr(0, 8'h01);
    waitIrq(20, t);
    chk("split irq", 16'h0100, {7'h00, ei, 7'h00, oi});
    chk("split reload", 16'h0005, 16'(ec));
    chk("reload regs", 16'h0905, {orl, er});
  endtask
  // count 0x0100 needs a borrow; single-shot bits set must not matter
  task automatic joinedRun;
    int t;
    wr(3, 8'h03);
    wr(4, 8'h01);
    wr(2, 8'h01);
    wr(1, 8'h00);
    wr(0, 8'h1D);
    waitIrq(3000, t);
    chk("cycles to zero", 16'h0001, 16'(t >= 2040 && t <= 2060));
    chk("odd irq", 16'h0000, 16'(oi));
    chk("reload", 16'h0103, {oc, ec});
    chk("control", 16'h001D, ctl);
    step(8);
    chk("free run", 16'h0102, {oc, ec});
  endtask
  task automatic splitShot;
    int t;
    wr(0, 8'h00);
    wr(4, 8'h09);
    wr(2, 8'h03);
    wr(0, 8'h12);
    step(8);
    chk("first tick", 16'h0002, 16'(oc));
    waitIrq(40, t);
    chk("irq pair", 16'h0001, {7'h00, ei, 7'h00, oi});
    chk("shot end", 16'h1000, {ctl, oc});
    step(16);
    chk("stopped", 16'h0000, 16'(oc));
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    resetCheck();
    joinedRun();
    splitShot();
    splitReload();
    results();
  end
  // whole run is about 2200 clocks
  initial begin
    #400us;
    n_mismatch++;
    results();
  end
endmodule // testbench
`default_nettype wire
